// ---- design/vfce_defs.svh ----
// Offsets, field positions, reset values and widths of the fault-check enable bank
`ifndef VFCE_DEFS_SVH
`define VFCE_DEFS_SVH
`define VFCE_ADDR_W 8
`define VFCE_DATA_W 16
`define VFCE_ADDR_OVER 8'h1a
`define VFCE_ADDR_UNDER 8'h1b
`define VFCE_ADDR_AUX 8'h1c
`define VFCE_ADDR_STATUS 8'h30
`define VFCE_ADDR_MASK 8'h31
`define VFCE_ADDR_AUX_EFF 8'h32
`define VFCE_ADDR_LAST_OVER 8'h33
`define VFCE_ADDR_LAST_UNDER 8'h34
`define VFCE_ADDR_LAST_AUX 8'h35
`define VFCE_CELLS 14
`define VFCE_CELL_MSB 13
`define VFCE_BLK_BIT 14
`define VFCE_BANK_W 15
`define VFCE_AUX_W 6
`define VFCE_TWI_AUX_BITS 6'h03
`define VFCE_EVT_W 5
`define VFCE_EVT_CELL_OVER 0
`define VFCE_EVT_BLK_OVER 1
`define VFCE_EVT_CELL_UNDER 2
`define VFCE_EVT_BLK_UNDER 3
`define VFCE_EVT_AUX_COLD 4
`define VFCE_RST_WORD 16'h0000
`endif

// ---- design/vfce_pkg.sv ----
// Types shared by the fault-check enable bank
package vfce_pkg;
  `include "vfce_defs.svh"
  typedef logic [`VFCE_ADDR_W-1:0] vfce_addr_t;
  typedef logic [`VFCE_DATA_W-1:0] vfce_word_t;
  typedef logic [`VFCE_AUX_W-1:0] vfce_aux_t;
  typedef logic [`VFCE_CELLS-1:0] vfce_cell_t;
  typedef logic [`VFCE_EVT_W-1:0] vfce_evt_t;
  // Register selected by the current address
  typedef enum logic [8:0] {
    VFCE_SEL_NONE = 9'h001, VFCE_SEL_OVER = 9'h002, VFCE_SEL_UNDER = 9'h004,
    VFCE_SEL_AUX = 9'h008, VFCE_SEL_STATUS = 9'h010, VFCE_SEL_MASK = 9'h020,
    VFCE_SEL_AUX_EFF = 9'h040, VFCE_SEL_LAST_OV = 9'h080, VFCE_SEL_LAST_UV = 9'h100
  } vfce_sel_t;
endpackage

// ---- design/vfce_reg_if.sv ----
// Write path and state of one enable register
`timescale 1ns/1ps
interface vfce_reg_if #(parameter int WIDTH = 15);
  logic wr;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] value;
  logic [WIDTH-1:0] clr;
  modport owner (input wr, input wdata, output value, output clr);
  modport user (output wr, output wdata, input value, input clr);
endinterface

// ---- design/vfce_enable_reg.sv ----
// One enable register with an alert-clear pulse for each bit that falls
`timescale 1ns/1ps
module vfce_enable_reg #(parameter int WIDTH = 15) (
  input wire logic clk_in,      // System clock
  input wire logic rst_in,      // Async reset, high
  vfce_reg_if.owner bank        // Write path and state
);
  import vfce_pkg::*;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bank.value <= '0;
    end else if (bank.wr) begin
      bank.value <= bank.wdata;
    end
  end

  // Falling enable drops the latched alert; pulse lasts one cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bank.clr <= '0;
    end else if (bank.wr) begin
      bank.clr <= bank.value & ~bank.wdata;
    end else begin
      bank.clr <= '0;
    end
  end
endmodule

// ---- design/vfce_irq_ctrl.sv ----
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
module vfce_irq_ctrl (
  input wire logic clk_in,                  // System clock
  input wire logic rst_in,                  // Async reset, high
  input wire vfce_pkg::vfce_evt_t evt_in,   // Event pulses
  input wire logic mask_wr_in,              // Mask write
  input wire vfce_pkg::vfce_evt_t mask_in,  // New mask
  input wire logic status_rd_in,            // Status read, clears
  output vfce_pkg::vfce_evt_t status_out,   // Sticky status
  output vfce_pkg::vfce_evt_t mask_out,     // Mask, 1 enables
  output logic irq_out                      // Level interrupt
);
  import vfce_pkg::*;

  // Set wins over the read-clear so no event is lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_out <= '0;
    end else if (status_rd_in) begin
      status_out <= evt_in;
    end else begin
      status_out <= status_out | evt_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_out <= '0;
    end else if (mask_wr_in) begin
      mask_out <= mask_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_in & next_mask()) | (|(status_out & ~clr_now() & next_mask()));
    end
  end

  function automatic vfce_evt_t next_mask();
    return mask_wr_in ? mask_in : mask_out;
  endfunction

  function automatic vfce_evt_t clr_now();
    return status_rd_in ? status_out : '0;
  endfunction
endmodule

// ---- design/vfce_top.sv ----
// Overvoltage, undervoltage and cold fault-check enable bank with scan qualification
`timescale 1ns/1ps
`include "vfce_defs.svh"
module vfce_top (
  input wire logic CLK_IN,                                   // 25 MHz clock
  input wire logic RST_IN,                                   // Async reset, high
  input wire vfce_pkg::vfce_addr_t ADDR_IN,                  // Register address
  input wire vfce_pkg::vfce_word_t WDATA_IN,                 // Write data
  input wire logic WR_IN,                                    // Write strobe
  input wire logic RD_IN,                                    // Read strobe
  output vfce_pkg::vfce_word_t RDATA_OUT,                    // Read data, next cycle
  input wire vfce_pkg::vfce_aux_t PIN_GPIO_MODE_EN_IN,       // Aux pin in GPIO mode
  input wire logic PIN_TWOWIRE_MODE_EN_IN,                   // Aux 1:0 in two-wire mode
  input wire vfce_pkg::vfce_aux_t AUX_REFERENCE_SELECT_IN,   // 1 ratiometric, 0 absolute
  input wire logic SCAN_VALID_IN,                            // Scan hits valid
  input wire vfce_pkg::vfce_cell_t CELL_OVER_HIT_IN,         // Cell above threshold
  input wire logic BLOCK_OVER_HIT_IN,                        // Block above threshold
  input wire vfce_pkg::vfce_cell_t CELL_UNDER_HIT_IN,        // Cell below threshold
  input wire logic BLOCK_UNDER_HIT_IN,                       // Block below threshold
  input wire vfce_pkg::vfce_aux_t AUX_RATIO_COLD_HIT_IN,     // Ratiometric cold hit
  input wire vfce_pkg::vfce_aux_t AUX_ABS_COLD_HIT_IN,       // Absolute cold hit
  output vfce_pkg::vfce_cell_t CELL_OVER_CHECK_EN_OUT,       // Cell OV enables
  output logic BLOCK_OVER_CHECK_EN_OUT,                      // Block OV enable
  output vfce_pkg::vfce_cell_t CELL_UNDER_CHECK_EN_OUT,      // Cell UV enables
  output logic BLOCK_UNDER_CHECK_EN_OUT,                     // Block UV enable
  output vfce_pkg::vfce_aux_t AUX_COLD_CHECK_EN_OUT,         // Effective cold enables
  output vfce_pkg::vfce_cell_t CELL_OVER_FAULT_OUT,          // Qualified cell OV
  output logic BLOCK_OVER_FAULT_OUT,                         // Qualified block OV
  output vfce_pkg::vfce_cell_t CELL_UNDER_FAULT_OUT,         // Qualified cell UV
  output logic BLOCK_UNDER_FAULT_OUT,                        // Qualified block UV
  output vfce_pkg::vfce_aux_t AUX_COLD_FAULT_OUT,            // Qualified cold
  output vfce_pkg::vfce_cell_t CELL_OVER_ALERT_CLR_OUT,      // Cell OV alert clear
  output logic BLOCK_OVER_ALERT_CLR_OUT,                     // Block OV alert clear
  output vfce_pkg::vfce_cell_t CELL_UNDER_ALERT_CLR_OUT,     // Cell UV alert clear
  output logic BLOCK_UNDER_ALERT_CLR_OUT,                    // Block UV alert clear
  output vfce_pkg::vfce_aux_t AUX_COLD_ALERT_CLR_OUT,        // Cold alert clear
  output logic IRQ_OUT                                       // Level interrupt
);
  import vfce_pkg::*;

  vfce_sel_t sel;
  vfce_aux_t aux_eff;
  vfce_aux_t aux_hit;
  vfce_aux_t twi_bits;
  vfce_evt_t evt;
  vfce_evt_t status;
  vfce_evt_t mask;
  vfce_word_t next_rdata;
  logic [`VFCE_BANK_W-1:0] last_over;
  logic [`VFCE_BANK_W-1:0] last_under;
  vfce_aux_t aux_cold_en;

  vfce_reg_if #(.WIDTH(`VFCE_BANK_W)) over_bank ();
  vfce_reg_if #(.WIDTH(`VFCE_BANK_W)) under_bank ();
  vfce_reg_if #(.WIDTH(`VFCE_AUX_W)) aux_bank ();

  // Address decode
  always_comb begin
    unique case (ADDR_IN)
      `VFCE_ADDR_OVER: begin
        sel = VFCE_SEL_OVER;
      end
      `VFCE_ADDR_UNDER: begin
        sel = VFCE_SEL_UNDER;
      end
      `VFCE_ADDR_AUX: begin
        sel = VFCE_SEL_AUX;
      end
      `VFCE_ADDR_STATUS: begin
        sel = VFCE_SEL_STATUS;
      end
      `VFCE_ADDR_MASK: begin
        sel = VFCE_SEL_MASK;
      end
      `VFCE_ADDR_AUX_EFF: begin
        sel = VFCE_SEL_AUX_EFF;
      end
      `VFCE_ADDR_LAST_OVER: begin
        sel = VFCE_SEL_LAST_OV;
      end
      `VFCE_ADDR_LAST_UNDER: begin
        sel = VFCE_SEL_LAST_UV;
      end
      default: begin
        sel = VFCE_SEL_NONE;
      end
    endcase
  end

  // Bit 15 of the bank words is unused and never stored
  assign over_bank.wr = WR_IN && (sel == VFCE_SEL_OVER);
  assign over_bank.wdata = WDATA_IN[`VFCE_BANK_W-1:0];
  assign under_bank.wr = WR_IN && (sel == VFCE_SEL_UNDER);
  assign under_bank.wdata = WDATA_IN[`VFCE_BANK_W-1:0];
  assign aux_bank.wr = WR_IN && (sel == VFCE_SEL_AUX);
  assign aux_bank.wdata = WDATA_IN[`VFCE_AUX_W-1:0];

  vfce_enable_reg #(.WIDTH(`VFCE_BANK_W)) u_over (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .bank(over_bank.owner)
  );

  vfce_enable_reg #(.WIDTH(`VFCE_BANK_W)) u_under (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .bank(under_bank.owner)
  );

  vfce_enable_reg #(.WIDTH(`VFCE_AUX_W)) u_aux (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .bank(aux_bank.owner)
  );

  // stored enables drive the scan engine directly
  assign CELL_OVER_CHECK_EN_OUT = over_bank.value[`VFCE_CELL_MSB:0];
  assign BLOCK_OVER_CHECK_EN_OUT = over_bank.value[`VFCE_BLK_BIT];
  // stored enables drive the scan engine directly
  assign CELL_UNDER_CHECK_EN_OUT = under_bank.value[`VFCE_CELL_MSB:0];
  assign BLOCK_UNDER_CHECK_EN_OUT = under_bank.value[`VFCE_BLK_BIT];

  // alert clears on a falling enable
  assign CELL_OVER_ALERT_CLR_OUT = over_bank.clr[`VFCE_CELL_MSB:0];
  assign BLOCK_OVER_ALERT_CLR_OUT = over_bank.clr[`VFCE_BLK_BIT];
  // alert clears on a falling enable
  assign CELL_UNDER_ALERT_CLR_OUT = under_bank.clr[`VFCE_CELL_MSB:0];
  assign BLOCK_UNDER_ALERT_CLR_OUT = under_bank.clr[`VFCE_BLK_BIT];
  // cold alert clears, whether or not the pin mode hides the enable
  assign AUX_COLD_ALERT_CLR_OUT = aux_bank.clr;

  // two-wire mode takes aux pins 1:0
  assign twi_bits = PIN_TWOWIRE_MODE_EN_IN ? `VFCE_TWI_AUX_BITS : '0;

  // GPIO mode hides the enable without touching the stored bit
  assign aux_eff = aux_bank.value & ~PIN_GPIO_MODE_EN_IN & ~twi_bits;

  // reference select picks which threshold result counts
  assign aux_hit = (AUX_REFERENCE_SELECT_IN & AUX_RATIO_COLD_HIT_IN)
                 | (~AUX_REFERENCE_SELECT_IN & AUX_ABS_COLD_HIT_IN);

  // effective enables as seen by the scan engine
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aux_cold_en <= '0;
    end else begin
      aux_cold_en <= aux_eff;
    end
  end

  assign AUX_COLD_CHECK_EN_OUT = aux_cold_en;

  // overvoltage hits count only where enabled
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CELL_OVER_FAULT_OUT <= '0;
      BLOCK_OVER_FAULT_OUT <= 1'b0;
    end else if (SCAN_VALID_IN) begin
      CELL_OVER_FAULT_OUT <= CELL_OVER_HIT_IN & over_bank.value[`VFCE_CELL_MSB:0];
      BLOCK_OVER_FAULT_OUT <= BLOCK_OVER_HIT_IN & over_bank.value[`VFCE_BLK_BIT];
    end else begin
      CELL_OVER_FAULT_OUT <= '0;
      BLOCK_OVER_FAULT_OUT <= 1'b0;
    end
  end

  // undervoltage hits count only where enabled
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CELL_UNDER_FAULT_OUT <= '0;
      BLOCK_UNDER_FAULT_OUT <= 1'b0;
    end else if (SCAN_VALID_IN) begin
      CELL_UNDER_FAULT_OUT <= CELL_UNDER_HIT_IN & under_bank.value[`VFCE_CELL_MSB:0];
      BLOCK_UNDER_FAULT_OUT <= BLOCK_UNDER_HIT_IN & under_bank.value[`VFCE_BLK_BIT];
    end else begin
      CELL_UNDER_FAULT_OUT <= '0;
      BLOCK_UNDER_FAULT_OUT <= 1'b0;
    end
  end

  // cold hits count only where the effective enable is set
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      AUX_COLD_FAULT_OUT <= '0;
    end else if (SCAN_VALID_IN) begin
      AUX_COLD_FAULT_OUT <= aux_hit & aux_eff;
    end else begin
      AUX_COLD_FAULT_OUT <= '0;
    end
  end

  // Snapshot of the last scan's qualified overvoltage and undervoltage results for software
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      last_over <= '0;
      last_under <= '0;
    end else if (SCAN_VALID_IN) begin
      last_over <= over_bank.value & {BLOCK_OVER_HIT_IN, CELL_OVER_HIT_IN};
      last_under <= under_bank.value & {BLOCK_UNDER_HIT_IN, CELL_UNDER_HIT_IN};
    end
  end

  // Interrupt events: any qualified fault of each kind in this scan
  always_comb begin
    evt = '0;
    if (SCAN_VALID_IN) begin
      evt[`VFCE_EVT_CELL_OVER] = |(CELL_OVER_HIT_IN & over_bank.value[`VFCE_CELL_MSB:0]);
      evt[`VFCE_EVT_BLK_OVER] = BLOCK_OVER_HIT_IN & over_bank.value[`VFCE_BLK_BIT];
      evt[`VFCE_EVT_CELL_UNDER] = |(CELL_UNDER_HIT_IN & under_bank.value[`VFCE_CELL_MSB:0]);
      evt[`VFCE_EVT_BLK_UNDER] = BLOCK_UNDER_HIT_IN & under_bank.value[`VFCE_BLK_BIT];
      evt[`VFCE_EVT_AUX_COLD] = |(aux_hit & aux_eff);
    end
  end

  vfce_irq_ctrl u_irq (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .evt_in(evt),
    .mask_wr_in(WR_IN && (sel == VFCE_SEL_MASK)),
    .mask_in(WDATA_IN[`VFCE_EVT_W-1:0]),
    .status_rd_in(RD_IN && (sel == VFCE_SEL_STATUS)),
    .status_out(status),
    .mask_out(mask),
    .irq_out(IRQ_OUT)
  );

  // read mux: unused bits and unmapped addresses read zero
  always_comb begin
    next_rdata = `VFCE_RST_WORD;
    unique case (sel)
      VFCE_SEL_OVER: begin
        next_rdata = {1'b0, over_bank.value};
      end
      VFCE_SEL_UNDER: begin
        next_rdata = {1'b0, under_bank.value};
      end
      VFCE_SEL_AUX: begin
        // read back the stored bits, not the effective ones
        next_rdata = {10'h000, aux_bank.value};
      end
      VFCE_SEL_STATUS: begin
        next_rdata = {11'h000, status};
      end
      VFCE_SEL_MASK: begin
        next_rdata = {11'h000, mask};
      end
      VFCE_SEL_AUX_EFF: begin
        next_rdata = {10'h000, aux_eff};
      end
      VFCE_SEL_LAST_OV: begin
        next_rdata = {1'b0, last_over};
      end
      VFCE_SEL_LAST_UV: begin
        next_rdata = {1'b0, last_under};
      end
      VFCE_SEL_NONE: begin
        next_rdata = `VFCE_RST_WORD;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= `VFCE_RST_WORD;
    end else if (RD_IN) begin
      RDATA_OUT <= next_rdata;
    end else begin
      RDATA_OUT <= `VFCE_RST_WORD;
    end
  end
endmodule

// ---- test/vfce_checker.sv ----
// Concurrent checks on the ports of the fault-check enable bank
`timescale 1ns/1ps
module vfce_checker (
  input wire logic CLK_IN, RST_IN, WR_IN, RD_IN, SCAN_VALID_IN, PIN_TWOWIRE_MODE_EN_IN,
  input wire logic BLOCK_OVER_HIT_IN, BLOCK_UNDER_HIT_IN, BLOCK_OVER_CHECK_EN_OUT, BLOCK_UNDER_CHECK_EN_OUT,
  input wire logic BLOCK_OVER_FAULT_OUT, BLOCK_UNDER_FAULT_OUT, BLOCK_UNDER_ALERT_CLR_OUT,
  input wire vfce_pkg::vfce_addr_t ADDR_IN,
  input wire vfce_pkg::vfce_word_t WDATA_IN, RDATA_OUT,
  input wire vfce_pkg::vfce_aux_t PIN_GPIO_MODE_EN_IN, AUX_COLD_CHECK_EN_OUT, AUX_COLD_FAULT_OUT,
  input wire vfce_pkg::vfce_cell_t CELL_OVER_HIT_IN, CELL_UNDER_HIT_IN, CELL_OVER_CHECK_EN_OUT,
  input wire vfce_pkg::vfce_cell_t CELL_UNDER_CHECK_EN_OUT, CELL_OVER_FAULT_OUT, CELL_UNDER_FAULT_OUT,
  input wire vfce_pkg::vfce_cell_t CELL_OVER_ALERT_CLR_OUT
);
  import vfce_pkg::*;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_ov_wr;
    WR_IN && ADDR_IN == 8'h1a |=> {BLOCK_OVER_CHECK_EN_OUT, CELL_OVER_CHECK_EN_OUT} == $past(WDATA_IN[14:0]);
  endproperty
  a_ov_wr: assert property (p_ov_wr) else $error("overvoltage enables differ from write");
  property p_uv_wr;
    WR_IN && ADDR_IN == 8'h1b |=> {BLOCK_UNDER_CHECK_EN_OUT, CELL_UNDER_CHECK_EN_OUT} == $past(WDATA_IN[14:0]);
  endproperty
  a_uv_wr: assert property (p_uv_wr) else $error("undervoltage enables differ from write");
  property p_ov_fault;
    SCAN_VALID_IN |=> {BLOCK_OVER_FAULT_OUT, CELL_OVER_FAULT_OUT} ==
      $past({BLOCK_OVER_HIT_IN, CELL_OVER_HIT_IN} & {BLOCK_OVER_CHECK_EN_OUT, CELL_OVER_CHECK_EN_OUT});
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("overvoltage fault not qualified");
  property p_uv_fault;
    SCAN_VALID_IN |=> {BLOCK_UNDER_FAULT_OUT, CELL_UNDER_FAULT_OUT} ==
      $past({BLOCK_UNDER_HIT_IN, CELL_UNDER_HIT_IN} & {BLOCK_UNDER_CHECK_EN_OUT, CELL_UNDER_CHECK_EN_OUT});
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("undervoltage fault not qualified");
  property p_ov_clr;
    WR_IN && ADDR_IN == 8'h1a |=> CELL_OVER_ALERT_CLR_OUT == $past(CELL_OVER_CHECK_EN_OUT & ~WDATA_IN[13:0]);
  endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("cell alert clear wrong");
  property p_blk_uv_clr;
    WR_IN && ADDR_IN == 8'h1b |=> BLOCK_UNDER_ALERT_CLR_OUT == $past(BLOCK_UNDER_CHECK_EN_OUT && !WDATA_IN[14]);
  endproperty
  a_blk_uv_clr: assert property (p_blk_uv_clr) else $error("block alert clear wrong");
  property p_aux_eff;
    1'b1 |=> (AUX_COLD_CHECK_EN_OUT & ($past(PIN_GPIO_MODE_EN_IN) |
      {4'h0, {2{$past(PIN_TWOWIRE_MODE_EN_IN)}}})) == 6'h00;
  endproperty
  a_aux_eff: assert property (p_aux_eff) else $error("ignored cold enable still active");
  property p_rd_ov;
    RD_IN && ADDR_IN == 8'h1a |=>
      RDATA_OUT == {1'b0, $past(BLOCK_OVER_CHECK_EN_OUT), $past(CELL_OVER_CHECK_EN_OUT)};
  endproperty
  a_rd_ov: assert property (p_rd_ov) else $error("overvoltage readback wrong");
  property p_aux_fault;
    1'b1 |-> (AUX_COLD_FAULT_OUT & ~AUX_COLD_CHECK_EN_OUT) == 6'h00;
  endproperty
  a_aux_fault: assert property (p_aux_fault) else $error("cold fault on a disabled input");
  property p_rd_aux;
    RD_IN && ADDR_IN == 8'h1c |=> RDATA_OUT[15:6] == 10'h000;
  endproperty
  a_rd_aux: assert property (p_rd_aux) else $error("unused cold enable bits read nonzero");
endmodule

bind vfce_top vfce_checker i_chk (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the fault-check enable bank
`timescale 1ns/1ps
module tb_top;
  import vfce_pkg::*;
  typedef struct {vfce_addr_t a; vfce_word_t d; vfce_word_t r;} vfce_row_t;
  logic CLK_IN = 1'b0, RST_IN = 1'b1, WR_IN = 1'b0, RD_IN = 1'b0, SCAN_VALID_IN = 1'b0;
  logic PIN_TWOWIRE_MODE_EN_IN = 1'b0, BLOCK_OVER_HIT_IN = 1'b0, BLOCK_UNDER_HIT_IN = 1'b0, IRQ_OUT;
  logic BLOCK_OVER_CHECK_EN_OUT, BLOCK_UNDER_CHECK_EN_OUT, BLOCK_OVER_FAULT_OUT, BLOCK_UNDER_FAULT_OUT;
  logic BLOCK_OVER_ALERT_CLR_OUT, BLOCK_UNDER_ALERT_CLR_OUT;
  vfce_addr_t ADDR_IN = 8'h00;
  vfce_word_t WDATA_IN = 16'h0000, RDATA_OUT, got;
  vfce_aux_t PIN_GPIO_MODE_EN_IN = 6'h00, AUX_REFERENCE_SELECT_IN = 6'h00, AUX_RATIO_COLD_HIT_IN = 6'h00;
  vfce_aux_t AUX_ABS_COLD_HIT_IN = 6'h00, AUX_COLD_CHECK_EN_OUT, AUX_COLD_FAULT_OUT, AUX_COLD_ALERT_CLR_OUT;
  vfce_cell_t CELL_OVER_HIT_IN = 14'h0000, CELL_UNDER_HIT_IN = 14'h0000, CELL_OVER_CHECK_EN_OUT;
  vfce_cell_t CELL_UNDER_CHECK_EN_OUT, CELL_OVER_FAULT_OUT, CELL_UNDER_FAULT_OUT;
  vfce_cell_t CELL_OVER_ALERT_CLR_OUT, CELL_UNDER_ALERT_CLR_OUT;
  int mismatches = 0;
  int total_checks = 0;
  // Unused high bits are written as ones so that a leak shows in the readback
  vfce_row_t rows[7] = '{'{8'h1a, 16'hffff, 16'h7fff}, '{8'h1b, 16'hffff, 16'h7fff},
    '{8'h1c, 16'hffff, 16'h003f}, '{8'h1a, 16'h2a55, 16'h2a55}, '{8'h1b, 16'h4001, 16'h4001},
    '{8'h1c, 16'h0015, 16'h0015}, '{8'h35, 16'hffff, 16'h0000}};

  vfce_top i_dut (.*);

  always #20 CLK_IN = ~CLK_IN;

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input vfce_addr_t a, input vfce_word_t d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
    #1;
  endtask

  task automatic rd(input vfce_addr_t a, output vfce_word_t d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge CLK_IN);
    RD_IN <= 1'b0;
    #1;
    d = RDATA_OUT;
  endtask

  task automatic scan();
    @(posedge CLK_IN);
    SCAN_VALID_IN <= 1'b1;
    @(posedge CLK_IN);
    SCAN_VALID_IN <= 1'b0;
    #1;
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge CLK_IN);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge CLK_IN);
    chk("reset_en", {BLOCK_UNDER_CHECK_EN_OUT, CELL_UNDER_CHECK_EN_OUT}, 16'h0000);
    chk("reset_ov_en", {BLOCK_OVER_CHECK_EN_OUT, CELL_OVER_CHECK_EN_OUT}, 16'h0000);
    chk("reset_aux_en", AUX_COLD_CHECK_EN_OUT, 6'h00);
    RST_IN <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(vfce_addr_t'(8'h1a + i), got);
      chk("reset_rd", got, 16'h0000);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, got);
      chk("readback", got, rows[i].r);
    end
    // Falling enables pulse their alert clears for one cycle only
    wr(8'h1a, 16'h0a54);
    chk("ov_clr", CELL_OVER_ALERT_CLR_OUT, 14'h2001);
    chk("ov_en", {BLOCK_OVER_CHECK_EN_OUT, CELL_OVER_CHECK_EN_OUT}, 16'h0a54);
    @(posedge CLK_IN);
    #1;
    chk("ov_clr_end", CELL_OVER_ALERT_CLR_OUT, 14'h0000);
    wr(8'h1b, 16'h0001);
    chk("uv_blk_clr", BLOCK_UNDER_ALERT_CLR_OUT, 16'h0001);
    chk("uv_cell_clr", CELL_UNDER_ALERT_CLR_OUT, 14'h0000);
    @(posedge CLK_IN);
    PIN_GPIO_MODE_EN_IN <= 6'h01;
    wr(8'h1c, 16'h0004);
    chk("aux_clr", AUX_COLD_ALERT_CLR_OUT, 6'h11);
    // Scan with all cell and block hits high; only enabled, unmuted channels may fault
    wr(8'h1a, 16'h4003);
    wr(8'h1b, 16'h0002);
    wr(8'h1c, 16'h003f);
    wr(8'h31, 16'h001f);
    @(posedge CLK_IN);
    PIN_GPIO_MODE_EN_IN <= 6'h04;
    PIN_TWOWIRE_MODE_EN_IN <= 1'b1;
    AUX_REFERENCE_SELECT_IN <= 6'h2a;
    // Ratio and absolute hits differ so a swapped select shows
    AUX_RATIO_COLD_HIT_IN <= 6'h0f;
    AUX_ABS_COLD_HIT_IN <= 6'h30;
    CELL_OVER_HIT_IN <= 14'h3fff;
    CELL_UNDER_HIT_IN <= 14'h3fff;
    BLOCK_OVER_HIT_IN <= 1'b1;
    BLOCK_UNDER_HIT_IN <= 1'b1;
    scan();
    chk("ov_fault", CELL_OVER_FAULT_OUT, 14'h0003);
    chk("blk_ov_fault", BLOCK_OVER_FAULT_OUT, 16'h0001);
    chk("uv_fault", CELL_UNDER_FAULT_OUT, 14'h0002);
    chk("blk_uv_fault", BLOCK_UNDER_FAULT_OUT, 16'h0000);
    chk("aux_fault", AUX_COLD_FAULT_OUT, 6'h18);
    chk("aux_eff", AUX_COLD_CHECK_EN_OUT, 6'h38);
    chk("irq_set", IRQ_OUT, 16'h0001);
    rd(8'h1c, got);
    chk("aux_rd", got, 16'h003f);
    rd(8'h32, got);
    chk("aux_eff_rd", got, 16'h0038);
    rd(8'h33, got);
    chk("last_ov", got, 16'h4003);
    rd(8'h34, got);
    chk("last_uv", got, 16'h0002);
    rd(8'h30, got);
    chk("status", got, 16'h0017);
    chk("irq_clr", IRQ_OUT, 16'h0000);
    // Masked events stay silent but still reach the status register
    wr(8'h31, 16'h0001);
    rd(8'h31, got);
    chk("mask_rd", got, 16'h0001);
    @(posedge CLK_IN);
    CELL_OVER_HIT_IN <= 14'h0000;
    BLOCK_OVER_HIT_IN <= 1'b0;
    AUX_RATIO_COLD_HIT_IN <= 6'h00;
    AUX_ABS_COLD_HIT_IN <= 6'h00;
    scan();
    chk("uv_fault2", CELL_UNDER_FAULT_OUT, 14'h0002);
    chk("irq_masked", IRQ_OUT, 16'h0000);
    rd(8'h30, got);
    chk("status2", got, 16'h0004);
    wr(8'h1a, 16'h0003);
    chk("ov_blk_clr", BLOCK_OVER_ALERT_CLR_OUT, 16'h0001);
    // Mid-run reset drops every enable and the mask back to zero
    @(posedge CLK_IN);
    RST_IN <= 1'b1;
    repeat (2) @(posedge CLK_IN);
    chk("rst_ov_en", {BLOCK_OVER_CHECK_EN_OUT, CELL_OVER_CHECK_EN_OUT}, 16'h0000);
    chk("rst_uv_en", {BLOCK_UNDER_CHECK_EN_OUT, CELL_UNDER_CHECK_EN_OUT}, 16'h0000);
    chk("rst_aux_en", AUX_COLD_CHECK_EN_OUT, 6'h00);
    RST_IN <= 1'b0;
    rd(8'h1c, got);
    chk("rst_aux_rd", got, 16'h0000);
    rd(8'h31, got);
    chk("rst_mask_rd", got, 16'h0000);
    print_verdict();
  end
endmodule
